// ---- include/hsc_pkg.sv ----
// package for the host serial channel: constants, rate table, carriers
package hsc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int DIV_W = 12;
  localparam int BUF_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int CNT_W = 8;
  localparam int XOFF_PCT = 50;
  localparam int XON_PCT = 35;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] MSB_CLEAR = 8'h7f;
  localparam logic [CNT_W-1:0] FULL_LEVEL = CNT_W'(BUF_DEPTH);
  localparam logic [CNT_W-1:0] XOFF_LEVEL =
    CNT_W'(BUF_DEPTH * XOFF_PCT / 100);
  localparam logic [CNT_W-1:0] XON_LEVEL =
    CNT_W'(BUF_DEPTH * XON_PCT / 100);
  // start + 8 data + 2 stop
  localparam logic [3:0] FRAME_BITS = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [1:0] SKID_DEPTH = 2'h2;
  localparam int RATE_0 = 300;
  localparam int RATE_1 = 600;
  localparam int RATE_2 = 1200;
  localparam int RATE_3 = 2400;
  localparam int RATE_4 = 4800;
  localparam int RATE_5 = 9600;
  localparam int RATE_6 = 19200;
  localparam int RATE_8 = 300;
  localparam int RATE_9 = 600;

  typedef struct packed {
    logic [7:0] data;
  } hsc_char_s;

  typedef enum {TX_IDLE, TX_HOLD, TX_SHIFT} hsc_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsc_rx_e;

  function automatic logic [DIV_W-1:0] div_of(input int rate);
    div_of = DIV_W'(CLK_HZ / (OVERSAMPLE * rate));
  endfunction

  // zero divisor means no bit clock at all
  function automatic logic [DIV_W-1:0] rate_div(input logic [3:0] sel);
    case (sel)
      4'h0: rate_div = div_of(RATE_0);
      4'h1: rate_div = div_of(RATE_1);
      4'h2: rate_div = div_of(RATE_2);
      4'h3: rate_div = div_of(RATE_3);
      4'h4: rate_div = div_of(RATE_4);
      4'h5: rate_div = div_of(RATE_5);
      4'h6: rate_div = div_of(RATE_6);
      4'h8: rate_div = div_of(RATE_8);
      4'h9: rate_div = div_of(RATE_9);
      default: rate_div = '0;
    endcase
  endfunction
endpackage

// ---- core/hsc_top.sv ----
// host serial channel with hardware and software flow control
`timescale 1ns/1ns
`default_nettype none

module hsc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] rate_sel,
  input wire logic modem_role,
  input wire logic ser_in,
  input wire logic rts_in,
  input wire logic dtr_in,
  output logic ser_out,
  output logic cts_out,
  output logic dsr_out,
  input wire logic tx_valid,
  input wire hsc_pkg::hsc_char_s tx_char,
  output logic tx_ready,
  output logic rx_valid,
  output hsc_pkg::hsc_char_s rx_char,
  input wire logic rx_ready,
  output logic dtr_err,
  output logic frame_err,
  output logic overrun_err,
  output logic flow_halted
);
  // pin synchronisers: first stage is read only by the second
  logic [3:0] rate_m_q, rate_q;
  logic [3:0] pins_m_q, pins_q;
  logic rxd_s, rts_s, dtr_s, modem_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      rate_m_q <= '0;
      rate_q <= '0;
      pins_m_q <= 4'h1;
      pins_q <= 4'h1;
    end else if (clk_en) begin
      rate_m_q <= rate_sel;
      rate_q <= rate_m_q;
      pins_m_q <= {modem_role, dtr_in, rts_in, ser_in};
      pins_q <= pins_m_q;
    end
  end

  assign rxd_s = pins_q[0];
  assign rts_s = pins_q[1];
  assign dtr_s = pins_q[2];
  assign modem_s = pins_q[3];

  // oversampling bit clock
  logic [hsc_pkg::DIV_W-1:0] div_w;
  logic [hsc_pkg::DIV_W-1:0] baud_cnt_q;
  logic tick_w;

  // unused codes give a zero divisor and park the counter
  assign div_w = hsc_pkg::rate_div(rate_q);
  assign tick_w = (div_w != '0) && (baud_cnt_q == div_w - 1'b1);

  always_ff @(posedge clock) begin
    if (rst || (clk_en && (tick_w || div_w == '0))) begin
      baud_cnt_q <= '0;
    end else if (clk_en) begin
      baud_cnt_q <= baud_cnt_q + 1'b1;
    end
  end

  // two-entry buffer on the transmit input
  hsc_pkg::hsc_char_s skid_q [2];
  logic skid_wr_q, skid_rd_q;
  logic [1:0] skid_cnt_q, skid_cnt_d;
  logic skid_push, skid_pop, skid_valid;
  hsc_pkg::hsc_char_s skid_head;

  assign skid_push = tx_valid && tx_ready;
  assign skid_valid = skid_cnt_q != 2'h0;
  assign skid_head = skid_q[skid_rd_q];
  assign skid_cnt_d = skid_cnt_q + {1'b0, skid_push} - {1'b0, skid_pop};

  always_ff @(posedge clock) begin
    if (rst) begin
      skid_wr_q <= 1'b0;
      skid_rd_q <= 1'b0;
      skid_cnt_q <= '0;
      tx_ready <= 1'b0;
    end else if (clk_en) begin
      if (skid_push) begin
        skid_q[skid_wr_q] <= tx_char;
        skid_wr_q <= ~skid_wr_q;
      end
      if (skid_pop) begin
        skid_rd_q <= ~skid_rd_q;
      end
      skid_cnt_q <= skid_cnt_d;
      tx_ready <= skid_cnt_d != hsc_pkg::SKID_DEPTH;
    end
  end

  // receive buffer
  hsc_pkg::hsc_char_s rbuf_q [hsc_pkg::BUF_DEPTH];
  logic [hsc_pkg::PTR_W-1:0] rb_wr_q, rb_rd_q;
  logic [hsc_pkg::CNT_W-1:0] rb_cnt_q;
  logic [hsc_pkg::CNT_W-1:0] rb_cnt_d;
  logic rb_push, rb_pop, rb_full;

  // transmit side
  hsc_pkg::hsc_tx_e tx_state_q;
  logic [7:0] hold_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bit_q, tx_tick_q;
  logic xoff_sent_q;
  logic xoff_req, xon_req, ctrl_go, tx_idle, tx_go, tx_bit_end;
  logic tx_last;
  logic [7:0] ctrl_char;
  logic [7:0] tx_data7;
  logic [10:0] tx_frame;

  assign tx_idle = tx_state_q == hsc_pkg::TX_IDLE;
  assign xoff_req = !xoff_sent_q && rb_cnt_q >= hsc_pkg::XOFF_LEVEL;
  assign xon_req = xoff_sent_q && rb_cnt_q <= hsc_pkg::XON_LEVEL;
  // flow characters jump the queue and ignore our own halt
  assign ctrl_go = tx_idle && (xoff_req || xon_req);
  // halt is checked only between frames, so only a char already in TX_HOLD or a flow char follows
  assign skid_pop = tx_idle && !ctrl_go && skid_valid && !flow_halted;
  assign tx_go = tick_w && rts_s && dtr_s;
  assign tx_bit_end = tick_w && tx_tick_q == hsc_pkg::TICK_LAST;
  assign tx_last = tx_bit_end && tx_bit_q == hsc_pkg::FRAME_BITS - 4'h1;
  assign ctrl_char =
    xoff_req ? hsc_pkg::XOFF_CHAR : hsc_pkg::XON_CHAR;
  assign tx_data7 = hold_q & hsc_pkg::MSB_CLEAR;
  // two stop bits, start bit low; no parity
  assign tx_frame = {2'b11, tx_data7, 1'b0};

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state_q <= hsc_pkg::TX_IDLE;
      hold_q <= '0;
      xoff_sent_q <= 1'b0;
      dtr_err <= 1'b0;
    end else if (clk_en) begin
      dtr_err <= skid_pop && !dtr_s;
      unique case (tx_state_q)
        hsc_pkg::TX_IDLE: begin
          if (ctrl_go) begin
            hold_q <= ctrl_char;
            xoff_sent_q <= xoff_req;
            tx_state_q <= hsc_pkg::TX_HOLD;
          end else if (skid_pop && dtr_s) begin
            hold_q <= skid_head.data;
            tx_state_q <= hsc_pkg::TX_HOLD;
          end
        end
        hsc_pkg::TX_HOLD: begin
          if (tx_go) begin
            tx_state_q <= hsc_pkg::TX_SHIFT;
          end
        end
        hsc_pkg::TX_SHIFT: begin
          if (tx_last) begin
            tx_state_q <= hsc_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_tick_q <= '0;
      ser_out <= 1'b1;
    end else if (clk_en) begin
      if (tx_state_q == hsc_pkg::TX_HOLD && tx_go) begin
        tx_sh_q <= tx_frame;
        tx_bit_q <= '0;
        tx_tick_q <= '0;
      end else if (tx_state_q == hsc_pkg::TX_SHIFT && tick_w) begin
        tx_tick_q <= tx_tick_q + 4'h1;
        if (tx_bit_end) begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
        end
      end
      ser_out <= (tx_state_q == hsc_pkg::TX_SHIFT) ? tx_sh_q[0] : 1'b1;
    end
  end

  // receive side
  hsc_pkg::hsc_rx_e rx_state_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_bit_q, rx_tick_q;
  logic rx_got_q;
  logic [7:0] rx_got_data;
  logic got_xoff, got_xon, got_data;
  logic rx_mid, rx_end;

  assign rx_mid = rx_tick_q == hsc_pkg::SAMPLE_MID;
  assign rx_end = rx_tick_q == hsc_pkg::TICK_LAST;

  assign rx_got_data = rx_sh_q & hsc_pkg::MSB_CLEAR;
  assign got_xoff = rx_got_q && rx_got_data == hsc_pkg::XOFF_CHAR;
  assign got_xon = rx_got_q && rx_got_data == hsc_pkg::XON_CHAR;
  assign got_data = rx_got_q && !got_xoff && !got_xon;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_state_q <= hsc_pkg::RX_IDLE;
      rx_sh_q <= '0;
      rx_bit_q <= '0;
      rx_tick_q <= '0;
      rx_got_q <= 1'b0;
      frame_err <= 1'b0;
    end else if (clk_en) begin
      rx_got_q <= 1'b0;
      frame_err <= 1'b0;
      if (tick_w) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        unique case (rx_state_q)
          hsc_pkg::RX_IDLE: begin
            rx_tick_q <= '0;
            if (!rxd_s) begin
              rx_state_q <= hsc_pkg::RX_START;
            end
          end
          hsc_pkg::RX_START: begin
            if (rx_mid) begin
              rx_tick_q <= '0;
              rx_bit_q <= '0;
              // a glitch shorter than half a bit is not a start
              rx_state_q <= rxd_s ? hsc_pkg::RX_IDLE : hsc_pkg::RX_DATA;
            end
          end
          hsc_pkg::RX_DATA: begin
            if (rx_end) begin
              rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == hsc_pkg::DATA_LAST) begin
                rx_state_q <= hsc_pkg::RX_STOP;
              end
            end
          end
          hsc_pkg::RX_STOP: begin
            if (rx_end) begin
              // only the first stop bit is checked, so 1-stop senders work
              rx_got_q <= rxd_s;
              frame_err <= !rxd_s;
              rx_state_q <= hsc_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flow_halted <= 1'b0;
    end else if (clk_en) begin
      if (got_xoff) begin
        flow_halted <= 1'b1;
      end else if (got_xon) begin
        flow_halted <= 1'b0;
      end
    end
  end

  // data keeps being stored after our stop request, until full
  assign rb_full = rb_cnt_q == hsc_pkg::FULL_LEVEL;
  assign rb_push = got_data && !rb_full;
  assign rb_pop = (rb_cnt_q != '0) && (!rx_valid || rx_ready);
  assign rb_cnt_d = rb_cnt_q + {7'h00, rb_push} - {7'h00, rb_pop};
  // cts cannot stop a frame already on the wire; it is still stored unless the buffer is full

  always_ff @(posedge clock) begin
    if (rst) begin
      rb_wr_q <= '0;
      rb_rd_q <= '0;
      rb_cnt_q <= '0;
      overrun_err <= 1'b0;
    end else if (clk_en) begin
      overrun_err <= got_data && rb_full;
      if (rb_push) begin
        rbuf_q[rb_wr_q] <= hsc_pkg::hsc_char_s'(rx_got_data);
        rb_wr_q <= rb_wr_q + 1'b1;
      end
      if (rb_pop) begin
        rb_rd_q <= rb_rd_q + 1'b1;
      end
      rb_cnt_q <= rb_cnt_d;
    end
  end

  // holding stage; rx_valid is the receive ready flag
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_char <= '0;
    end else if (clk_en) begin
      if (rb_pop) begin
        rx_valid <= 1'b1;
        rx_char <= rbuf_q[rb_rd_q];
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
    end
  end

  // terminal role keeps both modem outputs inactive
  always_ff @(posedge clock) begin
    if (rst) begin
      cts_out <= 1'b0;
      dsr_out <= 1'b0;
    end else if (clk_en) begin
      cts_out <= modem_s && !rx_valid && !rb_full;
      dsr_out <= modem_s;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/hsc_top_checker.sv ----
// concurrent checks on the host serial channel ports
`timescale 1ns/1ns
`default_nettype none
module hsc_top_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic modem_role,
  input wire logic rts_in,
  input wire logic dtr_in,
  input wire logic ser_out,
  input wire logic cts_out,
  input wire logic dsr_out,
  input wire logic rx_valid,
  input wire hsc_pkg::hsc_char_s rx_char,
  input wire logic rx_ready,
  input wire logic dtr_err
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst || !clk_en);
  // four cycles cover the two sync flops plus the output register
  sequence s_modem_settled;
    modem_role [*4];
  endsequence
  sequence s_term_settled;
    !modem_role [*4];
  endsequence
  property p_dsr_on;
    s_modem_settled |-> dsr_out;
  endproperty
  a_dsr_on: assert property (p_dsr_on) else $error("dsr low");
  property p_term_quiet;
    s_term_settled |-> !cts_out && !dsr_out;
  endproperty
  a_term_quiet: assert property (p_term_quiet) else $error("lines up");
  property p_cts_busy;
    rx_valid [*2] |-> !cts_out;
  endproperty
  a_cts_busy: assert property (p_cts_busy) else $error("cts high");
  property p_cts_free;
    s_modem_settled ##0 (!rx_valid) [*2] |-> cts_out;
  endproperty
  a_cts_free: assert property (p_cts_free) else $error("cts low");
  property p_rx_msb;
    rx_valid |-> !rx_char.data[7];
  endproperty
  a_rx_msb: assert property (p_rx_msb) else $error("rx msb set");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_char);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx lost");
  property p_no_ctrl;
    rx_valid |-> rx_char.data != hsc_pkg::XOFF_CHAR &&
      rx_char.data != hsc_pkg::XON_CHAR;
  endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("ctrl out");
  // bench only drops rts between frames, so any fall is a start bit
  property p_hold_rts;
    (!rts_in) [*6] ##0 ser_out |=> ser_out;
  endproperty
  a_hold_rts: assert property (p_hold_rts) else $error("sent early");
  property p_dtr_err;
    dtr_err |-> !($past(dtr_in, 2) && $past(dtr_in, 3) && $past(dtr_in, 4));
  endproperty
  a_dtr_err: assert property (p_dtr_err) else $error("bad dtr err");
endmodule
bind hsc_top hsc_top_checker chk_u (
  .clock(clock), .rst(rst), .clk_en(clk_en), .modem_role(modem_role),
  .rts_in(rts_in), .dtr_in(dtr_in), .ser_out(ser_out), .cts_out(cts_out),
  .dsr_out(dsr_out), .rx_valid(rx_valid), .rx_char(rx_char),
  .rx_ready(rx_ready), .dtr_err(dtr_err)
);
`default_nettype wire

// ---- testbench/hsc_remote.sv ----
// behavioural remote terminal on the serial and handshake lines
`timescale 1ns/1ns
`default_nettype none
module hsc_remote #(
  parameter int BIT = 512
) (
  input wire logic clock,
  input wire logic ser_out,
  output var logic ser_in,
  output var logic rts_in,
  output var logic dtr_in
);
  logic [7:0] got[$];
  int bad_stop = 0;
  logic [7:0] rb;
  logic s1;
  initial begin
    ser_in = 1'b1;
    rts_in = 1'b1;
    dtr_in = 1'b1;
  end
  // caller sits on a falling edge
  task automatic send_frame(input logic [10:0] fr);
    for (int i = 0; i < 11; i++) begin
      ser_in = fr[i];
      repeat (BIT) @(negedge clock);
    end
  endtask
  task automatic send_byte(input logic [7:0] v);
    send_frame({2'b11, v, 1'b0});
  endtask
  always begin
    @(negedge ser_out);
    repeat (BIT / 2) @(negedge clock);
    if (ser_out === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge clock);
        rb[i] = ser_out;
      end
      repeat (BIT) @(negedge clock);
      s1 = ser_out;
      repeat (BIT) @(negedge clock);
      if (s1 === 1'b1 && ser_out === 1'b1) begin
        got.push_back(rb);
      end else begin
        bad_stop++;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_hsc_top.sv ----
// self-checking bench for the host serial channel
`timescale 1ns/1ns
`default_nettype none
module tb_hsc_top;
  localparam int BIT = hsc_pkg::OVERSAMPLE *
    (hsc_pkg::CLK_HZ / (hsc_pkg::OVERSAMPLE * hsc_pkg::RATE_6));
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] rate_sel = 4'h6;
  logic modem_role = 1'b1;
  logic tx_valid = 1'b0;
  hsc_pkg::hsc_char_s tx_char = '0;
  logic rx_ready = 1'b0;
  hsc_pkg::hsc_char_s rx_char;
  wire logic ser_in, rts_in, dtr_in, ser_out, cts_out, dsr_out, tx_ready;
  wire logic rx_valid, dtr_err, frame_err, overrun_err, flow_halted;
  int err_total = 0;
  int num_checks = 0;
  int ferr_cnt = 0;
  int oerr_cnt = 0;
  logic [7:0] b;
  logic seen;

  always #50 clock = ~clock;

  // error outputs are one-cycle pulses, so count them as they pass
  always @(posedge clock) begin
    if (frame_err === 1'b1)
      ferr_cnt++;
    if (overrun_err === 1'b1)
      oerr_cnt++;
  end

  hsc_top dut_u (
    .clock(clock), .rst(rst), .clk_en(clk_en), .rate_sel(rate_sel),
    .modem_role(modem_role), .ser_in(ser_in), .rts_in(rts_in),
    .dtr_in(dtr_in), .ser_out(ser_out), .cts_out(cts_out),
    .dsr_out(dsr_out), .tx_valid(tx_valid), .tx_char(tx_char),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_ready(rx_ready), .dtr_err(dtr_err), .frame_err(frame_err),
    .overrun_err(overrun_err), .flow_halted(flow_halted)
  );
  hsc_remote #(.BIT(BIT)) remote_u (
    .clock(clock), .ser_out(ser_out), .ser_in(ser_in), .rts_in(rts_in),
    .dtr_in(dtr_in)
  );

  task automatic check(input string what, input logic [7:0] got_v,
                       input logic [7:0] exp);
    num_checks++;
    if (got_v !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got_v);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // tx_ready looked at on the falling edge, taken on the next rise
  task automatic push(input logic [7:0] v);
    int n;
    n = 0;
    @(negedge clock);
    tx_valid = 1'b1;
    tx_char.data = v;
    while (tx_ready !== 1'b1 && n < 20 * BIT) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    tx_valid = 1'b0;
  endtask
  task automatic pull(output logic [7:0] v);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 20 * BIT) begin
      @(negedge clock);
      n++;
    end
    v = rx_char.data;
    rx_ready = 1'b1;
    @(negedge clock);
    rx_ready = 1'b0;
  endtask
  task automatic expect_sent(input logic [7:0] v);
    int n;
    logic [7:0] g;
    n = 0;
    while (remote_u.got.size() == 0 && n < 40 * BIT) begin
      @(negedge clock);
      n++;
    end
    g = 'x;
    if (remote_u.got.size() > 0)
      g = remote_u.got.pop_front();
    check("sent char", g, v & hsc_pkg::MSB_CLEAR);
  endtask
  task automatic quiet_for(input int bits, input string what);
    repeat (bits * BIT) @(negedge clock);
    check(what, 8'(remote_u.got.size()), 8'h00);
  endtask

  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check("dsr", dsr_out, 8'h01);
    check("cts idle", cts_out, 8'h01);
    check("line idle", ser_out, 8'h01);
    $display("test reset ended");
    remote_u.rts_in = 1'b0;
    push(8'ha5);
    push(8'hff);
    push(8'h3c);
    repeat (4) @(negedge clock);
    check("tx ready full", tx_ready, 8'h00);
    quiet_for(3, "held frames");
    remote_u.rts_in = 1'b1;
    expect_sent(8'ha5);
    expect_sent(8'hff);
    expect_sent(8'h3c);
    check("stop bits", 8'(remote_u.bad_stop), 8'h00);
    $display("test transmit ended");
    remote_u.dtr_in = 1'b0;
    repeat (4) @(negedge clock);
    push(8'h55);
    seen = 1'b0;
    repeat (4 * BIT) begin
      @(negedge clock);
      if (dtr_err === 1'b1)
        seen = 1'b1;
    end
    check("dtr error", seen, 8'h01);
    remote_u.dtr_in = 1'b1;
    quiet_for(2, "dropped char");
    $display("test dtr ended");
    remote_u.send_byte(8'hc1);
    check("cts busy", cts_out, 8'h00);
    pull(b);
    check("rx char", b, 8'h41);
    repeat (3) @(negedge clock);
    check("rx flag", rx_valid, 8'h00);
    check("cts free", cts_out, 8'h01);
    // first stop bit low, second high so the line ends idle
    remote_u.send_frame({2'b10, 8'h5a, 1'b0});
    repeat (BIT) @(negedge clock);
    check("frame err", 8'(ferr_cnt), 8'h01);
    check("bad frame kept", rx_valid, 8'h00);
    $display("test receive ended");
    remote_u.send_byte(hsc_pkg::XOFF_CHAR);
    check("halted", flow_halted, 8'h01);
    check("ctrl kept", rx_valid, 8'h00);
    push(8'h42);
    quiet_for(13, "halted frames");
    // terminal sends only the resume code after a stop, well under 64
    remote_u.send_byte(8'h91);
    check("resumed", flow_halted, 8'h00);
    expect_sent(8'h42);
    $display("test flow ended");
    rate_sel = 4'h7;
    push(8'ha1);
    quiet_for(13, "no bit clock");
    rate_sel = 4'h6;
    expect_sent(8'ha1);
    modem_role = 1'b0;
    repeat (5) @(negedge clock);
    check("term dsr", dsr_out, 8'h00);
    check("term cts", cts_out, 8'h00);
    check("overrun", 8'(oerr_cnt), 8'h00);
    $display("test rate and role ended");
    end_sim();
  end

  // roughly a third above the expected run length
  initial begin
    repeat (180 * BIT) @(posedge clock);
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
